// File: logic/nvm_byte_read_port.sv
`timescale 1ns/1ps
module nvm_byte_read_port
  import nvm_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Fabric read port
  input  wire logic                  rd_en,
  input  wire logic [ADDR_W-1:0]     rd_addr,
  output logic      [BYTE_BITS-1:0]  rd_data,
  // Test port (boundary scan or user TAP macro)
  input  wire logic                  tp_req,
  input  wire tp_op_e                tp_op,
  input  wire tp_src_e               tp_src,
  input  wire logic [BANK_SEL_W-1:0] tp_bank,
  input  wire logic [BANK_BITS-1:0]  tp_wdata,
  output logic                       tp_busy,
  output logic                       tp_done,
  output logic                       tp_refused,
  output logic      [BANK_BITS-1:0]  tp_rdata
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG  = 2'b10
  } prog_state_e;

  prog_state_e           state_reg;
  prog_state_e           state_next;
  logic [ADDR_W-1:0]     addr_reg;
  logic                  capt_reg;
  logic [BYTE_BITS-1:0]  rd_data_reg;
  logic [3:0]            erase_cnt_reg;
  logic [BANK_SEL_W-1:0] bank_reg;
  logic [BANK_BITS-1:0]  wdata_reg;
  logic [BANKS-1:0]      secure_reg;
  logic                  done_reg;
  logic                  refused_reg;
  logic [BANK_BITS-1:0]  tp_rdata_reg;
  logic                  take_req;
  logic                  read_blocked;

  nvm_array_if ifc ();

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  nvm_bank_array u_array (
    .sys_clk (sys_clk),
    .ifc     (ifc.array)
  );

  // ----------------------------------------------------------------
  // Fabric read path
  // ----------------------------------------------------------------
  // Address capture on the rising edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= RD_ADDR_RST;
      capt_reg <= 1'b0;
    end else begin
      capt_reg <= rd_en;
      if (rd_en) begin
        addr_reg <= rd_addr;
      end
    end
  end

  // Data launched on the falling edge, only after a fresh capture
  always_ff @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= RD_DATA_RST;
    end else if (capt_reg) begin
      rd_data_reg <= ifc.byte_q;
    end
  end

  assign rd_data       = rd_data_reg;
  assign ifc.byte_addr = addr_reg;

  // ----------------------------------------------------------------
  // Test-port command decode
  // ----------------------------------------------------------------
  assign take_req     = tp_req && (state_reg == ST_IDLE);
  assign read_blocked = (tp_src == SRC_SCAN_PORT) && secure_reg[tp_bank];

  // Sequencer next state: program always erases first
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take_req && tp_op == OP_PROGRAM) begin
          state_next = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (erase_cnt_reg == ERASE_CYCLES - 4'h1) begin
          state_next = ST_PROG;
        end
      end
      ST_PROG: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Erase duration counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_cnt_reg <= ERASE_CNT_RST;
    end else if (state_reg == ST_ERASE) begin
      erase_cnt_reg <= erase_cnt_reg + 4'h1;
    end else begin
      erase_cnt_reg <= ERASE_CNT_RST;
    end
  end

  // Command operands held for the whole program sequence
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_reg  <= '0;
      wdata_reg <= BANK_RST;
    end else if (take_req && tp_op == OP_PROGRAM) begin
      bank_reg  <= tp_bank;
      wdata_reg <= tp_wdata;
    end
  end

  // Per-bank security marks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      secure_reg <= SECURE_RST;
    end else if (take_req && tp_op == OP_SECURE) begin
      secure_reg[tp_bank] <= 1'b1;
    end
  end

  // Bank read-back, done and refusal pulses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg     <= 1'b0;
      refused_reg  <= 1'b0;
      tp_rdata_reg <= BANK_RST;
    end else begin
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      if (state_reg == ST_PROG) begin
        done_reg <= 1'b1;
      end else if (take_req && tp_op == OP_READ && read_blocked) begin
        refused_reg <= 1'b1;
      end else if (take_req && tp_op == OP_READ) begin
        tp_rdata_reg <= ifc.bank_q;
        done_reg     <= 1'b1;
      end else if (take_req) begin
        done_reg <= (tp_op == OP_SECURE);
      end
    end
  end

  // Array writes come only from the test-port sequencer
  assign ifc.bank_we    = (state_reg == ST_ERASE) || (state_reg == ST_PROG);
  assign ifc.bank_erase = (state_reg == ST_ERASE);
  assign ifc.wr_bank    = bank_reg;
  assign ifc.wr_data    = wdata_reg;
  assign ifc.rd_bank    = tp_bank;

  assign tp_busy    = (state_reg != ST_IDLE);
  assign tp_done    = done_reg;
  assign tp_refused = refused_reg;
  assign tp_rdata   = tp_rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_READ_CAPTURE: assert property (rd_en |=> addr_reg == $past(rd_addr))
    else $error("read address not captured on rising edge");

  AST_BYTE_VALUE: assert property ($past(rd_en) |-> rd_data == ifc.byte_q)
    else $error("read byte does not match addressed array byte");

  AST_DATA_HOLD: assert property (!$past(rd_en) |-> $stable(rd_data))
    else $error("read byte changed without a new address");

  AST_FABRIC_NO_WRITE: assert property (
    ifc.bank_we |-> $past(tp_busy) || $past(take_req && tp_op == OP_PROGRAM))
    else $error("array written outside a test-port program sequence");

  AST_ERASE_LENGTH: assert property (
    (take_req && tp_op == OP_PROGRAM) |=> (state_reg == ST_ERASE)[*5] ##1 state_reg == ST_PROG)
    else $error("bank erase did not last the erase time before programming");

  AST_PROG_AFTER_ERASE: assert property (
    state_reg == ST_PROG |-> $past(state_reg) == ST_ERASE && ifc.wr_bank == bank_reg)
    else $error("bank programmed without a preceding erase");

  AST_PROG_DONE: assert property (state_reg == ST_PROG |=> tp_done && !tp_busy)
    else $error("program sequence did not finish with done");

  AST_SECURE_REFUSE: assert property (
    (take_req && tp_op == OP_READ && read_blocked)
      |=> tp_refused && !tp_done && $stable(tp_rdata))
    else $error("secure bank read through boundary scan was not refused");

  AST_OPEN_READ: assert property (
    (take_req && tp_op == OP_READ && !read_blocked)
      |=> tp_done && !tp_refused && tp_rdata == $past(ifc.bank_q))
    else $error("permitted bank read did not return the bank");

  CV_FABRIC_READ:  cover property (rd_en ##1 !rd_en ##1 !rd_en);
  CV_PROGRAM:      cover property (take_req && tp_op == OP_PROGRAM ##[6:8] tp_done);
  CV_REFUSED:      cover property (tp_refused);
  CV_MACRO_SECURE: cover property (take_req && tp_op == OP_READ && tp_src == SRC_USER_TAP_MACRO
                                   && secure_reg[tp_bank]);

endmodule // nvm_byte_read_port

// File: logic/nvm_pkg.sv
package nvm_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int NVM_BITS       = 1024;
  localparam int BANKS          = 8;
  localparam int BANK_BITS      = 128;
  localparam int BYTES_PER_BANK = 16;
  localparam int BYTE_BITS      = 8;

  // ----------------------------------------------------------------
  // Fabric read address layout
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 7;
  localparam int BANK_SEL_W    = 3;
  localparam int BYTE_SEL_W    = 4;
  localparam int BANK_SEL_MSB  = 6;
  localparam int BANK_SEL_LSB  = 4;
  localparam int BYTE_SEL_MSB  = 3;
  localparam int BYTE_SEL_LSB  = 0;

  // ----------------------------------------------------------------
  // Reset and erased values
  // ----------------------------------------------------------------
  localparam logic [BYTE_BITS-1:0] RD_DATA_RST  = 8'h00;
  localparam logic [ADDR_W-1:0]    RD_ADDR_RST  = 7'h00;
  localparam logic [BANKS-1:0]     SECURE_RST   = 8'h00;
  localparam logic [BANK_BITS-1:0] BANK_RST     = 128'h0;
  localparam logic [BANK_BITS-1:0] ERASED_BANK  = {BANK_BITS{1'b1}};

  // ----------------------------------------------------------------
  // Timing: on-chip bank erase before programming
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int ERASE_TIME_NS = 100;
  localparam logic [3:0] ERASE_CYCLES =
    4'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] ERASE_CNT_RST = 4'h0;

  // ----------------------------------------------------------------
  // Test-port commands and sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ    = 2'b00,
    OP_PROGRAM = 2'b01,
    OP_SECURE  = 2'b10
  } tp_op_e;

  typedef enum logic {
    SRC_SCAN_PORT      = 1'b0,
    SRC_USER_TAP_MACRO = 1'b1
  } tp_src_e;

endpackage

// File: logic/nvm_array_if.sv
`timescale 1ns/1ps
// Link between the access control and the storage array
interface nvm_array_if;
  import nvm_pkg::*;

  logic                  bank_we;
  logic                  bank_erase;
  logic [BANK_SEL_W-1:0] wr_bank;
  logic [BANK_BITS-1:0]  wr_data;
  logic [BANK_SEL_W-1:0] rd_bank;
  logic [BANK_BITS-1:0]  bank_q;
  logic [ADDR_W-1:0]     byte_addr;
  logic [BYTE_BITS-1:0]  byte_q;

  modport ctrl  (output bank_we, bank_erase, wr_bank, wr_data, rd_bank, byte_addr,
                 input  bank_q, byte_q);
  modport array (input  bank_we, bank_erase, wr_bank, wr_data, rd_bank, byte_addr,
                 output bank_q, byte_q);
endinterface // nvm_array_if

// File: logic/nvm_bank_array.sv
`timescale 1ns/1ps
module nvm_bank_array
  import nvm_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Control side
  nvm_array_if.array ifc
);

  // ----------------------------------------------------------------
  // Storage: contents are not touched by reset
  // ----------------------------------------------------------------
  logic [BANK_BITS-1:0] mem [BANKS];

  // Whole-bank erase or program, never partial
  always_ff @(posedge sys_clk) begin
    if (ifc.bank_we) begin
      mem[ifc.wr_bank] <= ifc.bank_erase ? ERASED_BANK : ifc.wr_data;
    end
  end

  // Bank read for the test port
  assign ifc.bank_q = mem[ifc.rd_bank];

  // Byte read: upper bits pick the bank, lower bits the byte
  assign ifc.byte_q = mem[ifc.byte_addr[BANK_SEL_MSB:BANK_SEL_LSB]]
                         [ifc.byte_addr[BYTE_SEL_MSB:BYTE_SEL_LSB]*BYTE_BITS +: BYTE_BITS];

endmodule // nvm_bank_array

// File: testbench/fabric_reader.sv
`timescale 1ns/1ps
module fabric_reader
  import nvm_pkg::*;
(
  // Clock
  input  wire logic                 sys_clk,
  // Fabric read port
  output logic                      rd_en,
  output logic      [ADDR_W-1:0]    rd_addr,
  input  wire logic [BYTE_BITS-1:0] rd_data
);
  // Idle fabric: no request, address bus parked on a junk value
  initial begin
    rd_en   = 1'b0;
    rd_addr = 7'h55;
  end

  // One byte read: address held through the capturing rising edge
  task automatic read_byte(input logic [ADDR_W-1:0] addr, output logic [BYTE_BITS-1:0] data);
    @(negedge sys_clk);
    rd_en   = 1'b1;
    rd_addr = addr;
    @(posedge sys_clk);
    @(negedge sys_clk);
    rd_en   = 1'b0;
    rd_addr = ~addr;                 // Released bus never keeps the old address
    @(posedge sys_clk);
    data = rd_data;
  endtask
endmodule // fabric_reader

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import nvm_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                  sys_clk, rst_n, rd_en, tp_req, tp_busy, tp_done, tp_refused;
  logic [ADDR_W-1:0]     rd_addr;
  logic [BYTE_BITS-1:0]  rd_data, d;
  tp_op_e                tp_op;
  tp_src_e               tp_src;
  logic [BANK_SEL_W-1:0] tp_bank;
  logic [BANK_BITS-1:0]  tp_wdata, tp_rdata;
  logic [BANK_BITS-1:0]  image [BANKS];
  int                    bad_count, comparisons, cycles, n;

  nvm_byte_read_port u_nvm_byte_read_port (.sys_clk(sys_clk), .rst_n(rst_n), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .tp_req(tp_req), .tp_op(tp_op), .tp_src(tp_src),
    .tp_bank(tp_bank), .tp_wdata(tp_wdata), .tp_busy(tp_busy), .tp_done(tp_done),
    .tp_refused(tp_refused), .tp_rdata(tp_rdata));
  fabric_reader u_fabric_reader (.sys_clk(sys_clk), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data));

  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [BANK_BITS-1:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Test-port command; n counts the mid-cycle samples up to and including the one that sees done or refusal
  task automatic tp_cmd(input tp_op_e op, input tp_src_e src, input int b,
                        input logic [BANK_BITS-1:0] wd);
    @(negedge sys_clk);
    tp_req   = 1'b1;
    tp_op    = op;
    tp_src   = src;
    tp_bank  = 3'(b);
    tp_wdata = wd;
    @(posedge sys_clk);
    @(negedge sys_clk);
    tp_req   = 1'b0;
    tp_wdata = ~wd;
    check("tp_busy", tp_busy, 128'(op == OP_PROGRAM));
    // One-cycle pulses are looked at mid-cycle, while they stand
    n = 0;
    while (n < 20) begin
      n++;
      if (tp_done === 1'b1 || tp_refused === 1'b1) break;
      @(negedge sys_clk);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset held for 16 cycles, released off the rising edge
  task automatic test_reset();
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    check("rst rd_data", rd_data, 8'h00);
    check("rst tp_rdata", tp_rdata, '0);
    check("rst flags", 128'({tp_busy, tp_done, tp_refused}), '0);
    $display("test_reset done");
  endtask

  task automatic test_program_all();
    for (int b = 0; b < BANKS; b++) begin
      for (int k = 0; k < BYTES_PER_BANK; k++) image[b][8*k +: 8] = 8'(b*16 + k) ^ 8'hA5;
      tp_cmd(OP_PROGRAM, SRC_SCAN_PORT, b, image[b]);
      check("program cycles", 128'(n), 128'd7);
    end
    for (int a = 0; a < BANKS*BYTES_PER_BANK; a++) begin
      u_fabric_reader.read_byte(7'(a), d);
      check("fabric byte", d, image[a/16][8*(a%16) +: 8]);
    end
    for (int b = 0; b < BANKS; b++) begin
      tp_cmd(OP_READ, tp_src_e'(b % 2), b, '0);
      check("bank readback", tp_rdata, image[b]);
    end
    $display("test_program_all done");
  endtask

  task automatic test_secure();
    tp_cmd(OP_SECURE, SRC_SCAN_PORT, 3, '0);
    check("secure done", 128'(tp_done), 128'd1);
    tp_cmd(OP_READ, SRC_SCAN_PORT, 5, '0);
    tp_cmd(OP_READ, SRC_SCAN_PORT, 3, '0);
    check("refused", 128'(tp_refused), 128'd1);
    check("rdata kept", tp_rdata, image[5]);
    tp_cmd(OP_READ, SRC_USER_TAP_MACRO, 3, '0);
    check("macro read", tp_rdata, image[3]);
    u_fabric_reader.read_byte(7'h3C, d);
    check("fabric secure", d, image[3][103:96]);
    $display("test_secure done");
  endtask

  // Fabric read lands inside the erase phase, then the output must hold
  task automatic test_erase_hold();
    image[6] = {16{8'h3C}};
    fork
      tp_cmd(OP_PROGRAM, SRC_USER_TAP_MACRO, 6, image[6]);
      begin
        repeat (3) @(posedge sys_clk);
        u_fabric_reader.read_byte(7'h62, d);
        check("erased byte", d, 8'hFF);
      end
    join
    repeat (2) @(posedge sys_clk);
    check("held byte", rd_data, 8'hFF);
    u_fabric_reader.read_byte(7'h62, d);
    check("new byte", d, 8'h3C);
    $display("test_erase_hold done");
  endtask

  // Main sequence
  initial begin
    rst_n    = 1'b0;
    tp_req   = 1'b0;
    tp_op    = OP_READ;
    tp_src   = SRC_SCAN_PORT;
    tp_bank  = 3'h0;
    tp_wdata = '0;
    test_reset();
    test_program_all();
    test_secure();
    test_erase_hold();
    print_verdict();
  end
endmodule // testbench
